//--- hw/swb_params.svh
// Offsets, field positions, reset values and timing counts of the sleep/beeper block
// Operation
// - Sleep after neutral held for set interval
// - Ignore drive commands while asleep
// - Zero interval never sleeps
// - Key-plus-throttle sleep flashes lamp every 5s
// - Key-only wake needs key off then on
// - Key-plus-throttle wakes on key or throttle
// - Swap inverts wig-wag throttle polarity only
// - Motor reverse flips motor direction only
// - Master beeper enable gates every beep
// - Flash code beeps match flash count
// - Sleep entry beeps one second continuously
// - Reverse beeper beeps only in reverse
// - Both-direction mode beeps on any motion
// - Motion beep mode none, reverse, both
// - Beeper cycles programmed on and off times
// - Deep discharge beeps at cut-off voltage
`ifndef SWB_PARAMS_SVH
`define SWB_PARAMS_SVH

// Register byte offsets
`define SWB_CFG_OFS 8'h00
`define SWB_SLEEP_OFS 8'h04
`define SWB_ON_OFS 8'h08
`define SWB_OFF_OFS 8'h0C
`define SWB_STAT_OFS 8'h10
`define SWB_MASK_OFS 8'h14
`define SWB_STATE_OFS 8'h18

// Reset values
`define SWB_CFG_RST 12'h05F
`define SWB_SLEEP_RST 6'h0F
`define SWB_ON_RST 11'h12C
`define SWB_OFF_RST 11'h2BC
`define SWB_MASK_RST 4'h0

// Ranges
`define SWB_SLEEP_MAX 6'h32
`define SWB_ON_MIN 11'h064
`define SWB_ON_MAX 11'h5DC
`define SWB_OFF_MAX 11'h5DC

// Status bit positions
`define SWB_ST_SLEEP 0
`define SWB_ST_WAKE 1
`define SWB_ST_LOWBAT 2
`define SWB_ST_FLASH 3

// Timing
`define SWB_CLK_PERIOD_NS 10
`define SWB_MS_NS 1000000
`define SWB_SEC_MS 1000
`define SWB_MIN_SEC 60
`define SWB_LAMP_PERIOD_MS 5000
`define SWB_LAMP_ON_MS 100
`define SWB_SLEEP_BEEP_MS 1000

`endif

//--- hw/swb_pkg.sv
// Types of the sleep/beeper block
package swb_pkg;

  typedef enum logic [1:0] {
    SWB_AWAKE = 2'b00,
    SWB_ASLEEP = 2'b01,
    SWB_KEYOFF = 2'b11
  } swb_state_t;

  typedef enum logic [1:0] {
    SWB_MB_NONE = 2'b00,
    SWB_MB_REV = 2'b01,
    SWB_MB_BOTH = 2'b10
  } swb_motion_t;

  typedef enum logic [1:0] {
    SWB_TT_WIGWAG = 2'b00,
    SWB_TT_SINGLE = 2'b01,
    SWB_TT_UNIPOLAR = 2'b10
  } swb_thr_t;

  typedef struct packed {
    swb_thr_t thr_type;
    logic motor_rev;
    logic swap_dir;
    logic wake_key_only;
    logic dd_beep;
    swb_motion_t motion;
    logic rev_beep;
    logic sleep_beep;
    logic flash_beep;
    logic beep_en;
  } swb_cfg_t;

  typedef struct packed {
    logic key_on;
    logic neutral;
    logic defl_rev;
    logic fr_rev;
    logic moving;
    logic low_batt;
  } swb_user_t;

endpackage

//--- hw/swb_ctrl.sv
// Sleep, wake, direction and beeper controller with Avalon-MM registers
`include "swb_params.svh"

module swb_ctrl #(
  parameter int MS_CYC = `SWB_MS_NS / `SWB_CLK_PERIOD_NS
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // User side
  input wire swb_pkg::swb_user_t user,
  input wire logic flash_start,
  input wire logic [3:0] flash_count,
  // Outputs
  output logic drive_en,
  output logic motor_rev,
  output logic rev_limit_sel,
  output logic beeper,
  output logic lamp_pulse,
  output logic asleep,
  output logic irq
);

  localparam int MSW = (MS_CYC > 1) ? $clog2(MS_CYC) : 1;

  if (MS_CYC < 1) begin : g_chk
    $error("MS_CYC must be at least 1");
  end

  // Registers
  swb_pkg::swb_cfg_t cfg;
  logic [5:0] sleep_min;
  logic [10:0] on_ms;
  logic [10:0] off_ms;
  logic [3:0] status;
  logic [3:0] mask;

  // Internal state
  swb_pkg::swb_state_t state;
  logic [MSW-1:0] ms_cnt;
  logic ms_tick;
  logic [9:0] sec_ms;
  logic sec_tick;
  logic [11:0] neu_sec;
  logic [12:0] lamp_ms;
  logic [9:0] sbeep_ms;
  logic [10:0] ph_ms;
  logic phase_on;
  logic [3:0] flash_left;
  logic lowbat_q;

  // Bus strobes
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  assign bus_req = avs_read | avs_write;
  assign bus_wr = avs_write & ~avs_waitrequest;
  assign bus_rd = avs_read & ~avs_waitrequest;

  // Derived conditions
  logic [11:0] sleep_sec;
  logic go_sleep;
  logic key_cycle;
  logic wake;
  logic cmd_rev;
  logic motion_act;
  logic dd_act;
  logic flash_act;
  logic iv_act;
  logic ph_end_on;
  logic ph_end_off;
  logic [3:0] ev;

  assign sleep_sec = 12'(sleep_min * `SWB_MIN_SEC);

  // Neutral held for full interval; zero never sleeps
  assign go_sleep = (state == swb_pkg::SWB_AWAKE) && (sleep_min != 6'h00)
    && user.neutral && (neu_sec >= sleep_sec);

  // Key seen off while asleep and now on again
  assign key_cycle = (state == swb_pkg::SWB_KEYOFF) && user.key_on;

  // Throttle wakes only in key-plus-throttle style
  assign wake = key_cycle ||
    (state == swb_pkg::SWB_ASLEEP && !cfg.wake_key_only && !user.neutral);

  // Swap only applies to wig-wag throttles
  assign cmd_rev = (cfg.thr_type == swb_pkg::SWB_TT_WIGWAG) ?
    (user.defl_rev ^ cfg.swap_dir) : user.fr_rev;

  // Motion beep source selection
  always_comb begin
    motion_act = 1'b0;
    if (user.moving && state == swb_pkg::SWB_AWAKE) begin
      unique case (cfg.motion)
        swb_pkg::SWB_MB_NONE: motion_act = 1'b0;
        swb_pkg::SWB_MB_REV: motion_act = cfg.rev_beep & cmd_rev;
        swb_pkg::SWB_MB_BOTH: motion_act = 1'b1;
        default: motion_act = 1'b0;
      endcase
    end
  end

  assign dd_act = cfg.dd_beep & user.low_batt;
  assign flash_act = cfg.flash_beep & (flash_left != 4'h0);
  assign iv_act = motion_act | dd_act | flash_act;
  assign ph_end_on = ms_tick && phase_on && (ph_ms + 11'h001 >= on_ms);
  assign ph_end_off = ms_tick && !phase_on && (ph_ms + 11'h001 >= off_ms);

  assign ev[`SWB_ST_SLEEP] = go_sleep;
  assign ev[`SWB_ST_WAKE] = wake;
  assign ev[`SWB_ST_LOWBAT] = user.low_batt & ~lowbat_q;
  assign ev[`SWB_ST_FLASH] = flash_act && ph_end_on && flash_left == 4'h1;

  // Bus handshake: one wait cycle, then accept
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else if (ce) begin
      avs_waitrequest <= !(bus_req && avs_waitrequest);
    end
  end

  // Read data, captured in the wait cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (ce && avs_read && avs_waitrequest) begin
      unique case (avs_address)
        `SWB_CFG_OFS: avs_readdata <= {20'h00000, cfg};
        `SWB_SLEEP_OFS: avs_readdata <= {26'h0000000, sleep_min};
        `SWB_ON_OFS: avs_readdata <= {21'h000000, on_ms};
        `SWB_OFF_OFS: avs_readdata <= {21'h000000, off_ms};
        `SWB_STAT_OFS: avs_readdata <= {28'h0000000, status | ev};
        `SWB_MASK_OFS: avs_readdata <= {28'h0000000, mask};
        `SWB_STATE_OFS: avs_readdata <= {26'h0000000, flash_left, state};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Configuration writes; sleep, on and off times clamped to legal ranges
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg <= swb_pkg::swb_cfg_t'(`SWB_CFG_RST);
      sleep_min <= `SWB_SLEEP_RST;
      on_ms <= `SWB_ON_RST;
      off_ms <= `SWB_OFF_RST;
      mask <= `SWB_MASK_RST;
    end else if (ce && bus_wr) begin
      unique case (avs_address)
        `SWB_CFG_OFS: cfg <= swb_pkg::swb_cfg_t'(avs_writedata[11:0]);
        `SWB_SLEEP_OFS: sleep_min <= (avs_writedata[5:0] > `SWB_SLEEP_MAX) ?
          `SWB_SLEEP_MAX : avs_writedata[5:0];
        `SWB_ON_OFS: on_ms <= (avs_writedata[10:0] < `SWB_ON_MIN) ? `SWB_ON_MIN :
          (avs_writedata[10:0] > `SWB_ON_MAX) ? `SWB_ON_MAX : avs_writedata[10:0];
        `SWB_OFF_OFS: off_ms <= (avs_writedata[10:0] > `SWB_OFF_MAX) ?
          `SWB_OFF_MAX : avs_writedata[10:0];
        `SWB_MASK_OFS: mask <= avs_writedata[3:0];
        default: ;
      endcase
    end
  end

  // Sticky status, cleared by read, set wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status <= 4'h0;
    end else if (ce) begin
      if (bus_rd && avs_address == `SWB_STAT_OFS) begin
        status <= ev;
      end else begin
        status <= status | ev;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(status & mask);
    end
  end

  // Millisecond and second ticks
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ms_cnt <= '0;
      ms_tick <= 1'b0;
    end else if (ce) begin
      ms_tick <= (ms_cnt == MSW'(MS_CYC - 1));
      if (ms_cnt == MSW'(MS_CYC - 1)) begin
        ms_cnt <= '0;
      end else begin
        ms_cnt <= ms_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sec_ms <= 10'h000;
      sec_tick <= 1'b0;
    end else if (ce) begin
      sec_tick <= 1'b0;
      if (ms_tick) begin
        if (sec_ms == 10'(`SWB_SEC_MS - 1)) begin
          sec_ms <= 10'h000;
          sec_tick <= 1'b1;
        end else begin
          sec_ms <= sec_ms + 10'h001;
        end
      end
    end
  end

  // Neutral duration in seconds
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      neu_sec <= 12'h000;
    end else if (ce) begin
      if (!user.neutral || state != swb_pkg::SWB_AWAKE) begin
        neu_sec <= 12'h000;
      end else if (sec_tick && neu_sec != 12'hFFF) begin
        neu_sec <= neu_sec + 12'h001;
      end
    end
  end

  // Sleep state machine
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= swb_pkg::SWB_AWAKE;
    end else if (ce) begin
      unique case (state)
        swb_pkg::SWB_AWAKE: begin
          if (go_sleep) begin
            state <= swb_pkg::SWB_ASLEEP;
          end
        end
        swb_pkg::SWB_ASLEEP: begin
          if (wake) begin
            state <= swb_pkg::SWB_AWAKE;
          end else if (!user.key_on) begin
            state <= swb_pkg::SWB_KEYOFF;
          end
        end
        swb_pkg::SWB_KEYOFF: begin
          if (key_cycle) begin
            state <= swb_pkg::SWB_AWAKE;
          end
        end
        default: state <= swb_pkg::SWB_AWAKE;
      endcase
    end
  end

  // Drive, direction and asleep outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      drive_en <= 1'b0;
      motor_rev <= 1'b0;
      rev_limit_sel <= 1'b0;
      asleep <= 1'b0;
      lowbat_q <= 1'b0;
    end else if (ce) begin
      drive_en <= !user.neutral && state == swb_pkg::SWB_AWAKE && !go_sleep;
      motor_rev <= cmd_rev ^ cfg.motor_rev;
      rev_limit_sel <= cmd_rev;
      asleep <= (state != swb_pkg::SWB_AWAKE || go_sleep) && !wake;
      lowbat_q <= user.low_batt;
    end
  end

  // Lamp flash while asleep in key-plus-throttle style
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lamp_ms <= 13'h0000;
      lamp_pulse <= 1'b0;
    end else if (ce) begin
      if (state == swb_pkg::SWB_AWAKE) begin
        lamp_ms <= 13'h0000;
        lamp_pulse <= 1'b0;
      end else begin
        if (ms_tick) begin
          if (lamp_ms == 13'(`SWB_LAMP_PERIOD_MS - 1)) begin
            lamp_ms <= 13'h0000;
          end else begin
            lamp_ms <= lamp_ms + 13'h0001;
          end
        end
        lamp_pulse <= !cfg.wake_key_only && !wake &&
          (lamp_ms < 13'(`SWB_LAMP_ON_MS));
      end
    end
  end

  // One-second continuous sleep beep
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sbeep_ms <= 10'h000;
    end else if (ce) begin
      if (go_sleep && cfg.sleep_beep) begin
        sbeep_ms <= 10'(`SWB_SLEEP_BEEP_MS);
      end else if (ms_tick && sbeep_ms != 10'h000) begin
        sbeep_ms <= sbeep_ms - 10'h001;
      end
    end
  end

  // Flash-code beep counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flash_left <= 4'h0;
    end else if (ce) begin
      if (flash_start) begin
        flash_left <= flash_count;
      end else if (ph_end_on && flash_left != 4'h0) begin
        flash_left <= flash_left - 4'h1;
      end
    end
  end

  // On/off interval generator, restarts when idle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_on <= 1'b1;
      ph_ms <= 11'h000;
    end else if (ce) begin
      if (!iv_act) begin
        phase_on <= 1'b1;
        ph_ms <= 11'h000;
      end else if (ph_end_on) begin
        phase_on <= (off_ms == 11'h000);
        ph_ms <= 11'h000;
      end else if (ph_end_off) begin
        phase_on <= 1'b1;
        ph_ms <= 11'h000;
      end else if (ms_tick) begin
        ph_ms <= ph_ms + 11'h001;
      end
    end
  end

  // Merged buzzer output, registered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      beeper <= 1'b0;
    end else if (ce) begin
      beeper <= cfg.beep_en &&
        ((sbeep_ms != 10'h000) || (phase_on && iv_act));
    end
  end

endmodule // swb_ctrl

//--- test/swb_chk.sv
// Port checker of the sleep/beeper controller
module swb_chk #(
  parameter int MS_CYC = 100000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // User side and outputs
  input wire swb_pkg::swb_user_t user,
  input wire logic drive_en,
  input wire logic lamp_pulse,
  input wire logic asleep
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  int unsigned ncnt;
  int unsigned lcnt;
  // Cycles of unbroken lamp flash
  always_ff @(posedge clk) begin
    if (!rst_n || !lamp_pulse) begin
      lcnt <= 0;
    end else begin
      lcnt <= lcnt + 1;
    end
  end
  // Cycles of unbroken neutral
  always_ff @(posedge clk) begin
    if (!rst_n || !user.neutral) begin
      ncnt <= 0;
    end else if (ncnt < 32'hFFFFFF) begin
      ncnt <= ncnt + 1;
    end
  end
  sequence s_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> s_ack)
    else $error("wait state not exactly one cycle");
  a_idle_wait: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("waitrequest low without request");
  a_sleep_no_drive: assert property (asleep |-> !drive_en)
    else $error("drive while asleep");
  a_neutral_stop: assert property (user.neutral |=> !drive_en)
    else $error("drive in neutral");
  a_drive_awake: assert property (!user.neutral && !asleep |=> drive_en)
    else $error("no drive when awake and deflected");
  a_lamp_asleep: assert property (lamp_pulse |-> asleep)
    else $error("lamp flash while awake");
  a_lamp_len: assert property ($fell(lamp_pulse) && asleep |->
    lcnt > 99 * MS_CYC && lcnt <= 100 * MS_CYC)
    else $error("lamp flash length wrong");
  a_sleep_delay: assert property ($rose(asleep) |-> ncnt >= 59 * 1000 * MS_CYC)
    else $error("sleep before neutral interval");
  a_sleep_hold: assert property (asleep && user.neutral && user.key_on
    && $past(user.key_on) |=> asleep)
    else $error("woke without cause");
endmodule // swb_chk

bind swb_ctrl swb_chk #(.MS_CYC(MS_CYC)) i_chk (
  .clk(clk),
  .rst_n(rst_n),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest),
  .user(user),
  .drive_en(drive_en),
  .lamp_pulse(lamp_pulse),
  .asleep(asleep)
);

//--- test/swb_user_model.sv
// Key switch, throttle, battery and motor model
module swb_user_model (
  // Clock
  input wire logic clk,
  // Commands from bench
  input wire logic key,
  input wire logic [1:0] thr,
  input wire logic fr,
  input wire logic batt_low,
  // Device output
  input wire logic drive_en,
  // User signals
  output swb_pkg::swb_user_t user
);
  timeunit 1ns;
  timeprecision 1ns;
  initial user = '0;
  // Throttle 0 neutral, 1 forward, 2 reverse
  always @(posedge clk) begin
    user.key_on <= key;
    user.neutral <= thr == 2'h0;
    user.defl_rev <= thr == 2'h2;
    user.fr_rev <= fr;
    user.moving <= drive_en;
    user.low_batt <= batt_low;
  end
endmodule // swb_user_model

//--- test/sleep_wake_beeper_control_tb_top.sv
// Testbench of the sleep/beeper controller
module sleep_wake_beeper_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, rd, wr, fs, key, fr, bl, de, mr, rl, bp, lp, sl, irq, wt;
  logic [7:0] ad, rn;
  logic [3:0] fc;
  logic [1:0] th;
  logic [31:0] wd, rdat, q;
  swb_pkg::swb_user_t usr;
  int err_count, checks, n, m, i, e;
  logic [31:0] rv[$] = '{32'h5F, 32'hF, 32'h12C, 32'h2BC, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [7:0] wa[5] = '{8'h04, 8'h08, 8'h0C, 8'h08, 8'h1C};
  logic [31:0] wv[5] = '{32'h3F, 32'h10, 32'h7FF, 32'h5DC, 32'hFF};
  logic [31:0] we[5] = '{32'h32, 32'h64, 32'h5DC, 32'h5DC, 32'h0};

  swb_ctrl #(.MS_CYC(1)) i_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .avs_address(ad),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat),
    .avs_waitrequest(wt), .user(usr), .flash_start(fs), .flash_count(fc), .drive_en(de),
    .motor_rev(mr), .rev_limit_sel(rl), .beeper(bp), .lamp_pulse(lp), .asleep(sl), .irq(irq));
  swb_user_model i_usr (.clk(clk), .key(key), .thr(th), .fr(fr), .batt_low(bl),
    .drive_en(de), .user(usr));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      err_count++;
      $display("BAD %s exp %h seen %h", nm, x, s);
    end
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    ad <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    @(posedge clk);
    while (wt !== 1'b0) @(posedge clk);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // High cycles in n, rising edges in m
  task automatic cnt(ref logic s, input int k);
    logic p;
    p = s;
    n = 0;
    m = 0;
    repeat (k) begin
      n += (s === 1'b1);
      m += (s === 1'b1 && p !== 1'b1);
      p = s;
      @(posedge clk);
    end
  endtask

  task print_verdict;
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (95000) @(posedge clk);
    err_count++;
    print_verdict;
  end

  initial begin
    {rst_n, rd, wr, fs, fr, bl, th, fc, ad, wd} = '0;
    key = 1'b1;
    rn = 8'h44;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, unmapped place, clamps
    for (i = 0; i < 8; i++) begin
      bus(1'b0, 8'(i * 4), 32'h0);
      chk("reset", q, rv[i]);
    end
    for (i = 0; i < 5; i++) begin
      bus(1'b1, wa[i], wv[i]);
      bus(1'b0, wa[i], 32'h0);
      chk("clamp", q, we[i]);
    end
    // Direction per type, swap and motor reverse
    for (i = 0; i < 12; i++) begin
      bus(1'b1, 8'h00, 32'((i % 3) << 10 | (i / 3 % 2) << 8 | (i / 6) << 9 | 1));
      rn = lfsr(rn);
      th <= rn[0] ? 2'h2 : 2'h1;
      fr <= rn[1];
      repeat (3) @(posedge clk);
      e = (i % 3 == 0) ? (rn[0] ^ (i / 3 % 2)) : rn[1];
      chk("rev cmd", rl, e);
      chk("motor dir", mr, e ^ (i / 6));
    end
    th <= 2'h0;
    fr <= 1'b0;
    // Motion beep modes
    bus(1'b1, 8'h0C, 32'h64);
    for (i = 0; i < 24; i++) begin
      bus(1'b1, 8'h00, 32'((i % 3) << 4 | (i / 3 % 2) << 3 | i / 12));
      th <= 2'(1 + i / 6 % 2);
      cnt(bp, 60);
      e = i / 12 == 1 && (i % 3 == 2 || (i % 3 == 1 && i / 3 % 2 == 1 && i / 6 % 2 == 1));
      chk("motion beep", n > 0, e);
      th <= 2'h0;
      repeat (250) @(posedge clk);
    end
    // On and off intervals
    bus(1'b1, 8'h08, 32'h78);
    bus(1'b1, 8'h0C, 32'h50);
    bus(1'b1, 8'h00, 32'h21);
    th <= 2'h1;
    while (bp !== 1'b1) @(posedge clk);
    for (n = 0; bp === 1'b1; n++) @(posedge clk);
    chk("on time", n, 120);
    for (n = 0; bp !== 1'b1; n++) @(posedge clk);
    chk("off time", n, 80);
    th <= 2'h0;
    // Flash code beeps and interrupt
    bus(1'b1, 8'h0C, 32'h64);
    bus(1'b1, 8'h14, 32'h8);
    for (i = 0; i < 2; i++) begin
      bus(1'b1, 8'h00, 32'(i * 2 + 1));
      fc <= 4'h3;
      fs <= 1'b1;
      @(posedge clk);
      fs <= 1'b0;
      cnt(bp, 800);
      chk("flash beeps", m, i * 3);
    end
    chk("irq set", irq, 1);
    bus(1'b1, 8'h14, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq masked", irq, 0);
    bus(1'b0, 8'h10, 32'h0);
    chk("status", q, 32'h8);
    bus(1'b1, 8'h14, 32'h8);
    repeat (2) @(posedge clk);
    chk("irq clear", irq, 0);
    // Deep discharge, master enable
    bl <= 1'b1;
    bus(1'b1, 8'h00, 32'h41);
    cnt(bp, 60);
    chk("dd beep", n > 0, 1);
    bus(1'b1, 8'h00, 32'h40);
    repeat (3) @(posedge clk);
    cnt(bp, 60);
    chk("beep off", n, 0);
    bl <= 1'b0;
    // Sleep after one unbroken neutral minute
    bus(1'b1, 8'h00, 32'h5F);
    bus(1'b1, 8'h04, 32'h1);
    th <= 2'h1;
    repeat (5) @(posedge clk);
    th <= 2'h0;
    for (n = 0; sl !== 1'b1; n++) @(posedge clk);
    chk("sleep time", n >= 59000 && n <= 61100, 1);
    cnt(bp, 1200);
    chk("sleep beep", n, 1000);
    cnt(lp, 5000);
    chk("lamp", m, 1);
    bus(1'b1, 8'h00, 32'hDF);
    th <= 2'h1;
    repeat (200) @(posedge clk);
    chk("key only", sl, 1);
    chk("no drive", de, 0);
    th <= 2'h0;
    bus(1'b1, 8'h00, 32'h5F);
    th <= 2'h1;
    repeat (4) @(posedge clk);
    chk("thr wake", sl, 0);
    bus(1'b1, 8'h04, 32'h0);
    th <= 2'h0;
    repeat (3000) @(posedge clk);
    chk("zero sleep", sl, 0);
    bus(1'b0, 8'h18, 32'h0);
    chk("state", q, 32'h0);
    bus(1'b0, 8'h10, 32'h0);
    chk("events", q, 32'h7);
    print_verdict;
  end
endmodule // sleep_wake_beeper_control_tb_top
